// file: bench/serial_host_model.sv
// Host serial master model that frames register transfers
`timescale 1ns/1ns
module serial_host_model (
  input  wire logic core_clk,   // Core clock, paces the serial edges
  output logic      sclk,       // Serial clock, still between frames
  output logic      sen_n,      // Frame enable, active low
  output logic      sdio_line,  // Resolved data pin level
  input  wire logic sdio_out,   // Device data pin value
  input  wire logic sdio_oe,    // Device data pin enable
  input  wire logic ser_out,    // Device four-wire read data
  input  wire logic ser_out_oe  // Device read data enable
);
  logic host_en;
  logic host_bit;
  logic last_r;

  // Released pin shows the inverse of its last level, so a stale value never passes
  assign sdio_line = sdio_oe ? sdio_out : (host_en ? host_bit : ~last_r);
  always_ff @(posedge core_clk) last_r <= sdio_line;

  // Idle: enable high, clock low
  initial begin
    sclk = 1'b0;
    sen_n = 1'b1;
    host_en = 1'b0;
    host_bit = 1'b0;
  end

  // Five core cycles per serial phase, above the three the port needs
  task automatic half();
    repeat (5) @(negedge core_clk);
  endtask

  // One frame: instruction then cnt+1 data bytes, write data right-aligned
  task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [4:0] a, input logic [31:0] wd,
                      input logic fw, output logic [31:0] rdv, output logic [3:0] park);
    logic [39:0] sh;
    logic bad;
    int i;
    sh = {rd, cnt, a, wd << (8 * (3 - cnt))};
    rdv = '0;
    bad = 1'b0;
    sen_n = 1'b0;
    half();
    for (i = 0; i < 8 * (cnt + 2); i++) begin
      host_en = (i < 8) || !rd;
      host_bit = sh[39 - i];
      half();
      if (i >= 8) begin
        rdv = {rdv[30:0], fw ? (ser_out_oe ? ser_out : ~ser_out) : sdio_line};
      end
      // Each pin may be driven only in its own mode and only in read data bytes
      bad = bad | (sdio_oe !== (rd & !fw & (i >= 8))) | (ser_out_oe !== (rd & fw & (i >= 8)));
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    park = {ser_out_oe, ser_out, sdio_oe, bad};
    sen_n = 1'b1;
    host_en = 1'b0;
    half();
  endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ns
module tb;
  logic        core_clk, rst_n, pll_en, pll_lock;
  logic        sclk, sen_n, sdio, sdio_out, sdio_oe, ser_out, ser_out_oe, lock_pin, pcs, mix_dly, sync_full;
  logic [7:0]  nco;
  logic [12:0] oa, ob;
  logic [10:0] qa, qb;
  logic [9:0]  qp;
  logic [11:0] ga, gb;
  logic [7:0]  shd [32];
  logic [57:0] ap;
  int          num_errors = 0;
  int          num_checks = 0;
  int          seed = 32'h91ac;

  serial_register_port i_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .SERIAL_ENABLE_N(sen_n), .SDIO_IN(sdio),
    .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .SERIAL_DATA_OUT(ser_out), .SERIAL_DATA_OUT_OE(ser_out_oe),
    .PLL_ENABLE(pll_en), .PLL_LOCK_IN(pll_lock), .LOCK_INDICATOR_PIN(lock_pin), .PIN_COUNT_SELECT(pcs),
    .NCO_PHASE_HIGH(nco), .OFFSET_A(oa), .OFFSET_B(ob), .QUAD_GAIN_A(qa), .QUAD_GAIN_B(qb), .QUAD_PHASE(qp),
    .OUTPUT_GAIN_A(ga), .OUTPUT_GAIN_B(gb), .COARSE_MIX_PHASE_DELAY(mix_dly), .SYNC_LATCH_FULL_RATE(sync_full)
  );
  serial_host_model i_host (
    .core_clk(core_clk), .sclk(sclk), .sen_n(sen_n), .sdio_line(sdio), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .ser_out(ser_out), .ser_out_oe(ser_out_oe)
  );

  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Bits each address keeps; unused bits and unmapped places read zero
  function automatic logic [7:0] msk(input logic [4:0] a);
    if (a == 5'h04) return 8'hef;
    if (a == 5'h11 || a == 5'h12) return 8'hf8;
    if (a == 5'h1b) return 8'hfc;
    if (a == 5'h1c) return 8'h01;
    if (a >= 5'h0e && a <= 5'h1a) return 8'hff;
    return 8'h00;
  endfunction

  // Applied correction words as the staged bytes assemble them
  function automatic logic [57:0] applied();
    return {shd[5'h11][7:3], shd[5'h0f], shd[5'h12][7:3], shd[5'h10], shd[5'h16][5:3], shd[5'h13],
            shd[5'h16][2:0], shd[5'h14], shd[5'h16][7:6], shd[5'h15]};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_outs();
    check({oa, ob, qa, qb, qp}, ap);
    check({ga, gb, nco, mix_dly, sync_full, pcs}, {shd[25][7:4], shd[23], shd[25][3:0], shd[24], shd[14],
          shd[27][2], shd[28][0], shd[4][7]});
  endtask

  // Write frame; expected state follows the decrementing address
  task automatic wr(input logic [4:0] a, input logic [1:0] cnt, input logic [31:0] d);
    logic [31:0] rv;
    logic [3:0]  pk;
    logic [4:0]  ak;
    int          k;
    i_host.xfer(1'b0, cnt, a, d, shd[4][7], rv, pk);
    for (k = 0; k <= cnt; k++) begin
      ak = a - k[4:0];
      shd[ak] = d[8 * (cnt - k) +: 8] & msk(ak);
      if (ak == 5'h0f) ap = applied();
    end
    check(pk, 4'h0);
    chk_outs();
  endtask

  task automatic rd(input logic [4:0] a, input logic [1:0] cnt);
    logic [31:0] rv, ex;
    logic [3:0]  pk;
    logic [4:0]  ak;
    int          k;
    ex = '0;
    for (k = 0; k <= cnt; k++) begin
      ak = a - k[4:0];
      ex = {ex[23:0], shd[ak]};
    end
    i_host.xfer(1'b1, cnt, a, 32'h0, shd[4][7], rv, pk);
    check(rv, ex);
    check(pk, {shd[4][7], 3'b000});
  endtask

  // Cycles between rising edges of the lock pin, bounded
  task automatic period(output int p);
    int n;
    for (n = 0; n < 20 && lock_pin !== 1'b0; n++) @(negedge core_clk);
    for (n = 0; n < 20 && lock_pin !== 1'b1; n++) @(negedge core_clk);
    for (p = 0; p < 20 && lock_pin !== 1'b0; p++) @(negedge core_clk);
    for (; p < 20 && lock_pin !== 1'b1; p++) @(negedge core_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (60000) @(negedge core_clk);
    num_errors++;
    give_verdict();
  end

  // Main sequence: reset values, staged writes in both modes, probe codes
  initial begin
    int i;
    int n;
    rst_n = 1'b0;
    pll_en = 1'b0;
    pll_lock = 1'b0;
    for (i = 0; i < 32; i++) shd[i] = (i == 25) ? 8'hff : 8'h00;
    ap = applied();
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk_outs();
    for (i = 14; i < 32; i++) rd(i[4:0], 2'd0);
    for (n = 0; n < 3; n++) begin
      wr(5'h04, 2'd0, {24'h0, n[0], 7'($random(seed))});
      wr(5'h16, 2'd3, $random(seed));
      wr(5'h12, 2'd2, $random(seed));
      rd(5'h16, 2'd3);
      wr(5'h0f, 2'd1, $random(seed));
      wr(5'h19, 2'd2, $random(seed));
      wr(5'h1f, 2'd3, $random(seed) & 32'hffffff01);
      wr(5'h1b, 2'd1, {16'h0, 8'($random(seed)), 8'h00});
      rd(5'h19, 2'd3);
      rd(5'h1f, 2'd3);
    end
    for (i = 0; i < 6; i++) begin
      pll_en = (i < 4);
      wr(5'h1b, 2'd0, {24'h0, (i < 3) ? 5'h1d + i[4:0] : ((i == 3) ? 5'h1c : 5'h1f), 3'b000});
      if (i < 3) begin
        period(n);
        check(n, 2 << i);
      end else begin
        pll_lock = 1'b1;
        repeat (4) @(negedge core_clk);
        check(lock_pin, 1'b1);
        pll_lock = 1'b0;
        repeat (4) @(negedge core_clk);
        check(lock_pin, 1'b0);
      end
    end
    give_verdict();
  end
endmodule

// file: logic/regport_pkg.sv
// Constants, register map and types for the serial register port
package regport_pkg;

  // Register map
  localparam int         REG_COUNT                      = 32;
  localparam logic [4:0] ADDR_CONFIG_WORD_THREE         = 5'h04;
  localparam logic [4:0] ADDR_NCO_PHASE_HIGH            = 5'h0e;
  localparam logic [4:0] ADDR_OFFSET_A_LOW              = 5'h0f;
  localparam logic [4:0] ADDR_OFFSET_B_LOW              = 5'h10;
  localparam logic [4:0] ADDR_OFFSET_A_HIGH             = 5'h11;
  localparam logic [4:0] ADDR_OFFSET_B_HIGH             = 5'h12;
  localparam logic [4:0] ADDR_QUAD_GAIN_A_LOW           = 5'h13;
  localparam logic [4:0] ADDR_QUAD_GAIN_B_LOW           = 5'h14;
  localparam logic [4:0] ADDR_QUAD_PHASE_LOW            = 5'h15;
  localparam logic [4:0] ADDR_QUAD_PHASE_GAIN_HIGH      = 5'h16;
  localparam logic [4:0] ADDR_OUTPUT_GAIN_A_LOW         = 5'h17;
  localparam logic [4:0] ADDR_OUTPUT_GAIN_B_LOW         = 5'h18;
  localparam logic [4:0] ADDR_OUTPUT_GAIN_HIGH_PAIR     = 5'h19;
  localparam logic [4:0] ADDR_FACTORY_CLOCK_CONTROL     = 5'h1a;
  localparam logic [4:0] ADDR_CLOCK_PROBE_AND_PHASE     = 5'h1b;
  localparam logic [4:0] ADDR_FACTORY_TEST_STROBE_CLOCK = 5'h1c;
  localparam logic [4:0] ADDR_RESERVED_SLOT_A           = 5'h1d;
  localparam logic [4:0] ADDR_RESERVED_SLOT_B           = 5'h1e;
  localparam logic [4:0] ADDR_RESERVED_SLOT_C           = 5'h1f;

  // Instruction byte layout
  localparam int INSTR_DIR_BIT   = 7;
  localparam int INSTR_COUNT_MSB = 6;
  localparam int INSTR_COUNT_LSB = 5;
  localparam int INSTR_ADDR_MSB  = 4;
  localparam int INSTR_ADDR_LSB  = 0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Field positions
  localparam int PIN_COUNT_SELECT_BIT   = 7;
  localparam int OFFSET_HIGH_MSB        = 7;
  localparam int OFFSET_HIGH_LSB        = 3;
  localparam int QUAD_PHASE_HIGH_MSB    = 7;
  localparam int QUAD_PHASE_HIGH_LSB    = 6;
  localparam int QUAD_GAIN_A_HIGH_MSB   = 5;
  localparam int QUAD_GAIN_A_HIGH_LSB   = 3;
  localparam int QUAD_GAIN_B_HIGH_MSB   = 2;
  localparam int QUAD_GAIN_B_HIGH_LSB   = 0;
  localparam int GAIN_A_HIGH_MSB        = 7;
  localparam int GAIN_A_HIGH_LSB        = 4;
  localparam int GAIN_B_HIGH_MSB        = 3;
  localparam int GAIN_B_HIGH_LSB        = 0;
  localparam int PROBE_SELECT_MSB       = 7;
  localparam int PROBE_SELECT_LSB       = 3;
  localparam int MIX_PHASE_DELAY_BIT    = 2;
  localparam int STROBE_CLOCK_BIT       = 0;

  // Clock probe codes
  localparam logic [4:0] PROBE_FULL_RATE    = 5'h1d;
  localparam logic [4:0] PROBE_HALF_RATE    = 5'h1e;
  localparam logic [4:0] PROBE_QUARTER_RATE = 5'h1f;

  // Reset values and stored-bit masks
  localparam logic [7:0] RESET_ZERO            = 8'h00;
  localparam logic [7:0] RESET_GAIN_HIGH_PAIR  = 8'hff;
  localparam logic [7:0] MASK_NONE             = 8'h00;
  localparam logic [7:0] MASK_FULL             = 8'hff;
  localparam logic [7:0] MASK_CONFIG_THREE     = 8'hef;
  localparam logic [7:0] MASK_OFFSET_HIGH      = 8'hf8;
  localparam logic [7:0] MASK_PROBE_AND_PHASE  = 8'hfc;
  localparam logic [7:0] MASK_STROBE_CLOCK     = 8'h01;

  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} port_state_t;

  // Bits that a register actually stores; all others read zero
  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    logic [7:0] m;
    m = MASK_NONE;
    if (a == ADDR_CONFIG_WORD_THREE) m = MASK_CONFIG_THREE;
    else if (a == ADDR_OFFSET_A_HIGH || a == ADDR_OFFSET_B_HIGH) m = MASK_OFFSET_HIGH;
    else if (a == ADDR_CLOCK_PROBE_AND_PHASE) m = MASK_PROBE_AND_PHASE;
    else if (a == ADDR_FACTORY_TEST_STROBE_CLOCK) m = MASK_STROBE_CLOCK;
    else if (a >= ADDR_NCO_PHASE_HIGH && a <= ADDR_FACTORY_CLOCK_CONTROL) m = MASK_FULL;
    return m;
  endfunction

  function automatic logic [7:0] reg_reset(input logic [4:0] a);
    return (a == ADDR_OUTPUT_GAIN_HIGH_PAIR) ? RESET_GAIN_HIGH_PAIR : RESET_ZERO;
  endfunction

endpackage

// file: logic/serial_register_port.sv
// Serial register port with staged correction registers and clock probe
//
// Notes on behaviour
// - Three-wire or four-wire mode by pin_count_select
// - Config bit set means four-wire, clear three-wire
// - Frame is instruction plus one to four bytes
// - Instruction: direction, byte count, five-bit address
// - Direction one reads, zero writes
// - Byte count code plus one gives data bytes
// - All bytes shifted most significant bit first
// - Address decrements for each following byte
// - Input sampled on rising serial clock edges
// - Three-wire data pin is bidirectional
// - Instruction byte is always input
// - Three-wire reads use data pin, out stays off
// - Four-wire reads drive the separate data out
// - Data out low after last bit till frame end
// - Correction words staged until offset A low written
// - Offset words 13 bits, high in upper five
// - Quadrature gains 11 bits, phase 10 bits
// - Output gains 12 bits, high nibbles reset ones
// - Address 0x0e holds NCO phase upper byte
// - Probe codes put divided clocks on lock pin while PLL_ENABLE is high
// - Mix phase delay sets coarse mixer start phase
// - Strobe latch clock selects full or divided rate
// - Reserved addresses ignore writes, read zero
`timescale 1ns/1ns
module serial_register_port
  import regport_pkg::*;
(
  input  wire logic        CORE_CLK,               // Core clock, 50 MHz
  input  wire logic        RST_N,                  // Synchronous reset, active low
  input  wire logic        SCLK,                   // Serial clock from host
  input  wire logic        SERIAL_ENABLE_N,        // Frame enable, active low
  input  wire logic        SDIO_IN,                // Data pin, input side
  output logic             SDIO_OUT,               // Data pin, output side
  output logic             SDIO_OE,                // Data pin drive enable
  output logic             SERIAL_DATA_OUT,        // Four-wire read data
  output logic             SERIAL_DATA_OUT_OE,     // Read data drive enable
  input  wire logic        PLL_ENABLE,             // PLL enabled, core-clock logic
  input  wire logic        PLL_LOCK_IN,            // PLL lock level, core-clock logic
  output logic             LOCK_INDICATOR_PIN,     // Lock or probe clock
  output logic             PIN_COUNT_SELECT,       // Four-wire mode in force
  output logic [7:0]       NCO_PHASE_HIGH,         // NCO phase bits 15:8
  output logic [12:0]      OFFSET_A,               // Applied offset A
  output logic [12:0]      OFFSET_B,               // Applied offset B
  output logic [10:0]      QUAD_GAIN_A,            // Applied quadrature gain A
  output logic [10:0]      QUAD_GAIN_B,            // Applied quadrature gain B
  output logic [9:0]       QUAD_PHASE,             // Applied quadrature phase
  output logic [11:0]      OUTPUT_GAIN_A,          // Channel A gain
  output logic [11:0]      OUTPUT_GAIN_B,          // Channel B gain
  output logic             COARSE_MIX_PHASE_DELAY, // Coarse mixer start phase
  output logic             SYNC_LATCH_FULL_RATE    // Strobe latched at full rate
);

  logic [1:0]   sclk_sync_r;
  logic [1:0]   enb_sync_r;
  logic [1:0]   sdi_sync_r;
  logic         sclk_prev_r;
  logic         sclk_s;
  logic         enb_low;
  logic         sdi_s;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         four_wire;
  logic [7:0]   rf_r [REG_COUNT];
  port_state_t  state_r;
  logic [2:0]   bit_cnt_r;
  logic [6:0]   shift_r;
  logic         is_read_r;
  logic [1:0]   bytes_left_r;
  logic [4:0]   addr_r;
  logic [7:0]   rd_sh_r;
  logic [7:0]   byte_in;
  logic         byte_done;
  logic         wr_en_r;
  logic [4:0]   wr_addr_r;
  logic [7:0]   wr_data_r;
  logic [2:0]   div_cnt_r;
  logic [4:0]   probe_sel;
  logic         commit;

  // Pin synchronisers; the host clock is far slower than the core clock
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sclk_sync_r <= 2'h0;
      enb_sync_r  <= 2'h3;
      sdi_sync_r  <= 2'h0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], SCLK};
      enb_sync_r  <= {enb_sync_r[0], SERIAL_ENABLE_N};
      sdi_sync_r  <= {sdi_sync_r[0], SDIO_IN};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  // Edges count only inside a frame
  assign sclk_s    = sclk_sync_r[1];
  assign enb_low   = !enb_sync_r[1];
  assign sdi_s     = sdi_sync_r[1];
  assign sclk_rise = enb_low && sclk_s && !sclk_prev_r;
  assign sclk_fall = enb_low && !sclk_s && sclk_prev_r;
  assign byte_in   = {shift_r, sdi_s};
  assign byte_done = sclk_rise && (bit_cnt_r == BIT_LAST);

  // Mode bit; set selects four-wire
  assign four_wire = rf_r[ADDR_CONFIG_WORD_THREE][PIN_COUNT_SELECT_BIT];

  // Register file, one entry per address; unstored bits never take a value
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
        rf_r[g] <= reg_reset(5'(g));
      end else if (wr_en_r && wr_addr_r == 5'(g)) begin
        rf_r[g] <= wr_data_r & reg_mask(5'(g));
      end
    end
  end

  // Bit counter and input shifter, MSB arrives first
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 7'h00;
    end else if (!enb_low) begin
      bit_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= byte_in[6:0];
    end
  end

  // Frame sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_r      <= ST_INSTR;
      is_read_r    <= 1'b0;
      bytes_left_r <= 2'h0;
      addr_r       <= 5'h00;
      rd_sh_r      <= 8'h00;
    end else if (!enb_low) begin
      state_r <= ST_INSTR;
    end else begin
      case (state_r)
        ST_INSTR: begin
          if (byte_done) begin
            is_read_r    <= byte_in[INSTR_DIR_BIT];
            bytes_left_r <= byte_in[INSTR_COUNT_MSB:INSTR_COUNT_LSB];
            addr_r       <= byte_in[INSTR_ADDR_MSB:INSTR_ADDR_LSB];
            rd_sh_r      <= rf_r[byte_in[INSTR_ADDR_MSB:INSTR_ADDR_LSB]];
            state_r      <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            if (bytes_left_r == 2'h0) begin
              state_r <= ST_DONE;
            end else begin
              bytes_left_r <= bytes_left_r - 2'h1;
              addr_r       <= addr_r - 5'h01;
              rd_sh_r      <= rf_r[addr_r - 5'h01];
            end
          end
        end
        ST_DONE: begin
          // Extra clocks beyond the byte count are ignored
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_INSTR;
        end
      endcase
    end
  end

  // Write strobe, one cycle after the last bit of each write byte
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= 5'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r   <= (state_r == ST_DATA) && byte_done && !is_read_r;
      wr_addr_r <= addr_r;
      wr_data_r <= byte_in;
    end
  end

  // Read drive on falling edges so the host samples on the next rise
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SDIO_OUT           <= 1'b0;
      SDIO_OE            <= 1'b0;
      SERIAL_DATA_OUT    <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
    end else if (!enb_low) begin
      SDIO_OE            <= 1'b0;
      SERIAL_DATA_OUT    <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
    end else if (sclk_fall && is_read_r) begin
      if (state_r == ST_DATA) begin
        if (four_wire) begin
          SERIAL_DATA_OUT    <= rd_sh_r[BIT_LAST - bit_cnt_r];
          SERIAL_DATA_OUT_OE <= 1'b1;
          SDIO_OE            <= 1'b0;
        end else begin
          SDIO_OUT           <= rd_sh_r[BIT_LAST - bit_cnt_r];
          SDIO_OE            <= 1'b1;
          SERIAL_DATA_OUT_OE <= 1'b0;
        end
      end else if (state_r == ST_DONE) begin
        // Pin released after the last bit; data out parks low
        SDIO_OE            <= 1'b0;
        SERIAL_DATA_OUT    <= 1'b0;
        SERIAL_DATA_OUT_OE <= four_wire;
      end
    end
  end

  // Staged words go live together when offset A low is written
  assign commit = wr_en_r && (wr_addr_r == ADDR_OFFSET_A_LOW);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      OFFSET_A    <= 13'h0000;
      OFFSET_B    <= 13'h0000;
      QUAD_GAIN_A <= 11'h000;
      QUAD_GAIN_B <= 11'h000;
      QUAD_PHASE  <= 10'h000;
    end else if (commit) begin
      OFFSET_A    <= {rf_r[ADDR_OFFSET_A_HIGH][OFFSET_HIGH_MSB:OFFSET_HIGH_LSB], wr_data_r};
      OFFSET_B    <= {rf_r[ADDR_OFFSET_B_HIGH][OFFSET_HIGH_MSB:OFFSET_HIGH_LSB],
                      rf_r[ADDR_OFFSET_B_LOW]};
      QUAD_GAIN_A <= {rf_r[ADDR_QUAD_PHASE_GAIN_HIGH][QUAD_GAIN_A_HIGH_MSB:QUAD_GAIN_A_HIGH_LSB],
                      rf_r[ADDR_QUAD_GAIN_A_LOW]};
      QUAD_GAIN_B <= {rf_r[ADDR_QUAD_PHASE_GAIN_HIGH][QUAD_GAIN_B_HIGH_MSB:QUAD_GAIN_B_HIGH_LSB],
                      rf_r[ADDR_QUAD_GAIN_B_LOW]};
      QUAD_PHASE  <= {rf_r[ADDR_QUAD_PHASE_GAIN_HIGH][QUAD_PHASE_HIGH_MSB:QUAD_PHASE_HIGH_LSB],
                      rf_r[ADDR_QUAD_PHASE_LOW]};
    end
  end

  // Words that take effect at once, one cycle after the write
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PIN_COUNT_SELECT       <= 1'b0;
      NCO_PHASE_HIGH         <= RESET_ZERO;
      OUTPUT_GAIN_A          <= {RESET_GAIN_HIGH_PAIR[GAIN_A_HIGH_MSB:GAIN_A_HIGH_LSB], RESET_ZERO};
      OUTPUT_GAIN_B          <= {RESET_GAIN_HIGH_PAIR[GAIN_B_HIGH_MSB:GAIN_B_HIGH_LSB], RESET_ZERO};
      COARSE_MIX_PHASE_DELAY <= 1'b0;
      SYNC_LATCH_FULL_RATE   <= 1'b0;
    end else begin
      PIN_COUNT_SELECT       <= four_wire;
      NCO_PHASE_HIGH         <= rf_r[ADDR_NCO_PHASE_HIGH];
      OUTPUT_GAIN_A          <= {rf_r[ADDR_OUTPUT_GAIN_HIGH_PAIR][GAIN_A_HIGH_MSB:GAIN_A_HIGH_LSB],
                                 rf_r[ADDR_OUTPUT_GAIN_A_LOW]};
      OUTPUT_GAIN_B          <= {rf_r[ADDR_OUTPUT_GAIN_HIGH_PAIR][GAIN_B_HIGH_MSB:GAIN_B_HIGH_LSB],
                                 rf_r[ADDR_OUTPUT_GAIN_B_LOW]};
      COARSE_MIX_PHASE_DELAY <= rf_r[ADDR_CLOCK_PROBE_AND_PHASE][MIX_PHASE_DELAY_BIT];
      SYNC_LATCH_FULL_RATE   <= rf_r[ADDR_FACTORY_TEST_STROBE_CLOCK][STROBE_CLOCK_BIT];
    end
  end

  // Probe clocks are core-clock dividers standing in for the sample clock
  assign probe_sel = rf_r[ADDR_CLOCK_PROBE_AND_PHASE][PROBE_SELECT_MSB:PROBE_SELECT_LSB];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      div_cnt_r          <= 3'h0;
      LOCK_INDICATOR_PIN <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
      if (!PLL_ENABLE) begin
        LOCK_INDICATOR_PIN <= PLL_LOCK_IN;
      end else begin
        case (probe_sel)
          PROBE_FULL_RATE:    LOCK_INDICATOR_PIN <= div_cnt_r[0];
          PROBE_HALF_RATE:    LOCK_INDICATOR_PIN <= div_cnt_r[1];
          PROBE_QUARTER_RATE: LOCK_INDICATOR_PIN <= div_cnt_r[2];
          default:            LOCK_INDICATOR_PIN <= PLL_LOCK_IN;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_sdo_idle_off: assert property (!enb_low && $past(!enb_low) |-> !SERIAL_DATA_OUT_OE)
    else $error("data out driven outside a frame");
  chk_three_wire_sdo: assert property ($rose(SERIAL_DATA_OUT_OE) |-> four_wire)
    else $error("data out driven in three-wire mode");
  chk_four_wire_pin: assert property ($rose(SDIO_OE) |-> !four_wire && is_read_r)
    else $error("data pin driven in four-wire mode or on write");
  chk_instr_input: assert property (state_r == ST_INSTR && $past(state_r == ST_INSTR) |-> !SDIO_OE)
    else $error("data pin driven during instruction");
  chk_stage_hold: assert property (wr_en_r && wr_addr_r != ADDR_OFFSET_A_LOW |=> $stable(OFFSET_B))
    else $error("staged word applied without commit");
  chk_commit_value: assert property (commit |=> OFFSET_A[7:0] == $past(wr_data_r))
    else $error("offset A low not applied on commit");
  chk_reserved_zero: assert property (rf_r[ADDR_RESERVED_SLOT_A] == 8'h00 && rf_r[ADDR_RESERVED_SLOT_B] == 8'h00
                                      && rf_r[ADDR_RESERVED_SLOT_C] == 8'h00)
    else $error("reserved address holds a value");
  chk_addr_decrement: assert property (state_r == ST_DATA && byte_done && bytes_left_r != 2'h0
                                       |=> addr_r == $past(addr_r) - 5'h01)
    else $error("address did not decrement");
  chk_last_byte_done: assert property (state_r == ST_DATA && byte_done && bytes_left_r == 2'h0
                                       && enb_low ##1 enb_low |-> state_r == ST_DONE)
    else $error("frame not closed after counted bytes");
  chk_lock_normal: assert property (!PLL_ENABLE |=> LOCK_INDICATOR_PIN == $past(PLL_LOCK_IN))
    else $error("lock pin not showing lock with PLL off");
  chk_write_on_rise: assert property (wr_en_r |-> $past(sclk_rise) && !$past(is_read_r))
    else $error("write strobe without rising edge");
  chk_done_low: assert property (four_wire && is_read_r && state_r == ST_DONE && sclk_fall
                                 |=> SERIAL_DATA_OUT_OE && !SERIAL_DATA_OUT)
    else $error("data out not parked low after read");

  cov_commit: cover property (commit);
  cov_four_wire_read: cover property (SERIAL_DATA_OUT_OE && state_r == ST_DATA);
  cov_three_wire_read: cover property (SDIO_OE && state_r == ST_DATA);
  cov_four_bytes: cover property (byte_done && state_r == ST_INSTR
                                  && byte_in[INSTR_COUNT_MSB:INSTR_COUNT_LSB] == 2'h3);

endmodule
